// *** rtl/tacf_pkg.sv ***
/*
 Shared constants of the tag command decoder: command bytes, field positions,
 reset values, address limits and the state encoding.
 Assumes a single clock domain and a byte-wide request stream from the framer.
*/
package tacf_pkg;
   // ---------------------------------------------------------------
   // Command bytes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_START = 8'h06;
   localparam logic [7:0] SUB_INVENTORY = 8'h00;
   localparam logic [7:0] SUB_SLOT_POLL = 8'h04;
   localparam logic [3:0] PROBE_CODE = 4'h6;
   localparam logic [3:0] PROBE_POLL_FIELD = 4'h0;
   localparam logic [7:0] CMD_READ = 8'h08;
   localparam logic [7:0] CMD_REQUEUE = 8'h0c;
   localparam logic [7:0] CMD_SELECT = 8'h0e;
   localparam logic [7:0] CMD_COMPLETE = 8'h0f;

   // ---------------------------------------------------------------
   // Field positions and limits
   // ---------------------------------------------------------------
   localparam int SLOT_LSB = 0;
   localparam int SLOT_MSB = 3;
   localparam logic [3:0] SLOT_ZERO = 4'h0;
   localparam logic [7:0] ADDR_LAST_USER = 8'h7f;
   localparam logic [7:0] ADDR_SYSTEM = 8'hff;
   localparam int READ_BYTES = 4;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] HANDLE_RESET = 8'h00;
   localparam logic [15:0] LFSR_SEED = 16'hace1;

   // ---------------------------------------------------------------
   // Tag states, gray along ready-inventory-selected-deselected
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      TACF_READY = 3'h0,
      TACF_INVENTORY = 3'h1,
      TACF_SELECTED = 3'h3,
      TACF_DESELECTED = 3'h2,
      TACF_DEACTIVATED = 3'h6
   } tacf_tag_state_t;

   // Request parse phase
   typedef enum logic [1:0] {
      TACF_P_CMD = 2'h0,
      TACF_P_ARG = 2'h1,
      TACF_P_WAIT = 2'h3
   } tacf_parse_t;
endpackage

// *** rtl/tacf_cmd_fsm.sv ***
/*
 Command decoder and state machine of a contactless memory tag.
 Assumes an upstream framer delivering request bytes with a frame-end strobe
 and CRC verdict, a block memory with fixed read latency of one cycle, and an
 answer framer that accepts one byte per ans_valid/ans_ready handshake.
*/
`timescale 1ns/100ps

module tacf_cmd_fsm #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [7:0] req_byte,
   input wire logic req_end,
   input wire logic req_crc_ok,
   output logic mem_rd,
   output logic [ADDR_W-1:0] mem_addr,
   input wire logic [31:0] mem_data,
   output logic ans_valid,
   output logic [7:0] ans_byte,
   output logic ans_last,
   input wire logic ans_ready,
   output logic [2:0] tag_state
);
   initial begin
      if (ADDR_W != 8) $error("tacf_cmd_fsm: address width must be 8");
   end

   // ---------------------------------------------------------------
   // State record
   // ---------------------------------------------------------------
   typedef struct packed {
      tacf_pkg::tacf_tag_state_t st;
      tacf_pkg::tacf_parse_t ph;
      logic [7:0] cmd;
      logic [7:0] arg;
      logic [1:0] nargs;
      logic bad;
      logic [7:0] handle;
      logic [15:0] lfsr;
      logic rd;
      logic fetch;
      logic [7:0] addr;
      logic [31:0] data;
      logic [2:0] left;
      logic valid;
      logic [7:0] obyte;
      logic last;
   } tacf_regs_t;

   tacf_regs_t r;
   tacf_regs_t next_r;
   logic fb;
   logic [31:0] shifted;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.rd = 1'b0;
      // Memory answers one cycle after the strobe, so wait a cycle
      next_r.fetch = r.rd;
      shifted = r.data >> 8;
      // Free-running random source, advances every cycle
      fb = r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10];
      next_r.lfsr = {r.lfsr[14:0], fb};

      // Answer byte streaming
      if (r.valid && ans_ready) begin
         if (r.left != 3'h0) begin
            next_r.obyte = r.data[7:0];
            next_r.data = shifted;
            next_r.left = r.left - 3'h1;
            next_r.last = (r.left == 3'h1);
         end else begin
            next_r.valid = 1'b0;
            next_r.last = 1'b0;
         end
      end
      // Memory word stands in the cycle after the read strobe
      if (r.fetch) begin
         next_r.obyte = mem_data[7:0];
         next_r.data = mem_data >> 8;
         next_r.left = 3'(tacf_pkg::READ_BYTES - 1);
         next_r.valid = 1'b1;
         next_r.last = 1'b0;
      end

      // Request byte capture
      if (req_valid && r.st != tacf_pkg::TACF_DEACTIVATED) begin
         unique case (r.ph)
            tacf_pkg::TACF_P_CMD: begin
               next_r.cmd = req_byte;
               next_r.nargs = 2'h0;
               next_r.ph = tacf_pkg::TACF_P_ARG;
            end
            tacf_pkg::TACF_P_ARG: begin
               if (r.nargs == 2'h0) next_r.arg = req_byte;
               else next_r.bad = 1'b1;
               if (r.nargs != 2'h3) next_r.nargs = r.nargs + 2'h1;
            end
            tacf_pkg::TACF_P_WAIT: begin
            end
         endcase
      end

      // Frame end: decode whole request
      if (req_end) begin
         next_r.ph = tacf_pkg::TACF_P_CMD;
         next_r.bad = 1'b0;
         if (req_crc_ok && !r.valid && !r.rd && !r.fetch
             && r.ph == tacf_pkg::TACF_P_ARG) begin
            decode();
         end
      end
   end

   // Command decode on a good frame
   function automatic void decode();
      logic one_arg;
      logic no_arg;
      logic [3:0] slot;
      one_arg = (r.nargs == 2'h1) && !r.bad;
      no_arg = (r.nargs == 2'h0);
      slot = r.lfsr[7:4];
      if (r.cmd == tacf_pkg::CMD_START && one_arg && r.arg == tacf_pkg::SUB_INVENTORY) begin
         if (r.st == tacf_pkg::TACF_READY) begin
            next_r.st = tacf_pkg::TACF_INVENTORY;
            next_r.handle = r.lfsr[7:0];
            answer(r.lfsr[7:0]);
         end
      end else if (r.cmd == tacf_pkg::CMD_START && one_arg
                   && r.arg == tacf_pkg::SUB_SLOT_POLL) begin
         if (r.st == tacf_pkg::TACF_INVENTORY) begin
            next_r.handle[tacf_pkg::SLOT_MSB:tacf_pkg::SLOT_LSB] = slot;
            if (slot == tacf_pkg::SLOT_ZERO)
               answer({r.handle[7:4], slot});
         end
      end else if (no_arg && r.cmd[3:0] == tacf_pkg::PROBE_CODE
                   && r.cmd[7:4] != tacf_pkg::PROBE_POLL_FIELD) begin
         if (r.st == tacf_pkg::TACF_INVENTORY
             && r.handle[tacf_pkg::SLOT_MSB:tacf_pkg::SLOT_LSB] == r.cmd[7:4])
            answer(r.handle);
      end else if (r.cmd == tacf_pkg::CMD_SELECT && one_arg) begin
         if (r.st != tacf_pkg::TACF_READY) begin
            if (r.arg == r.handle) begin
               next_r.st = tacf_pkg::TACF_SELECTED;
               answer(r.handle);
            end else if (r.st == tacf_pkg::TACF_SELECTED) begin
               next_r.st = tacf_pkg::TACF_DESELECTED;
            end
         end
      end else if (r.cmd == tacf_pkg::CMD_COMPLETE && no_arg) begin
         if (r.st == tacf_pkg::TACF_SELECTED)
            next_r.st = tacf_pkg::TACF_DEACTIVATED;
      end else if (r.cmd == tacf_pkg::CMD_REQUEUE && no_arg) begin
         if (r.st == tacf_pkg::TACF_SELECTED)
            next_r.st = tacf_pkg::TACF_INVENTORY;
      end else if (r.cmd == tacf_pkg::CMD_READ && one_arg) begin
         if (r.st == tacf_pkg::TACF_SELECTED
             && (r.arg <= tacf_pkg::ADDR_LAST_USER || r.arg == tacf_pkg::ADDR_SYSTEM)) begin
            next_r.rd = 1'b1;
            next_r.addr = r.arg;
         end
      end
   endfunction

   // One-byte answer
   function automatic void answer(input logic [7:0] b);
      next_r.obyte = b;
      next_r.left = 3'h0;
      next_r.valid = 1'b1;
      next_r.last = 1'b1;
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= tacf_pkg::TACF_READY;
         r.ph <= tacf_pkg::TACF_P_CMD;
         r.handle <= tacf_pkg::HANDLE_RESET;
         r.lfsr <= tacf_pkg::LFSR_SEED;
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign mem_rd = r.rd;
   assign mem_addr = r.addr;
   assign ans_valid = r.valid;
   assign ans_byte = r.obyte;
   assign ans_last = r.last;
   assign tag_state = r.st;
endmodule

// *** sim/tacf_cmd_fsm_sva.sv ***
/* Port checker of the tag decoder.
   Bound to every tacf_cmd_fsm; one clock domain. */
`timescale 1ns/100ps
module tacf_cmd_fsm_sva #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [7:0] req_byte,
   input wire logic req_end,
   input wire logic req_crc_ok,
   input wire logic mem_rd,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [31:0] mem_data,
   input wire logic ans_valid,
   input wire logic [7:0] ans_byte,
   input wire logic ans_last,
   input wire logic ans_ready,
   input wire logic [2:0] tag_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] b0, b1;
   logic rd_q;
   logic [31:0] word_q;
   // Last two request bytes, word of a read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         b0 <= 8'hff;
         b1 <= 8'hff;
         rd_q <= 1'b0;
         word_q <= 32'h0;
      end else begin
         b0 <= req_end ? 8'hff : (req_valid ? b1 : b0);
         b1 <= req_end ? 8'hff : (req_valid ? req_byte : b1);
         rd_q <= mem_rd;
         word_q <= rd_q ? mem_data : word_q;
      end
   end
   sequence s_req(logic [7:0] c0, logic [7:0] c1, logic [2:0] st);
      req_end && req_crc_ok && b0 == c0 && b1 == c1 && tag_state == st;
   endsequence
   property p_reset;
      $rose(rst_n) |-> tag_state == 3'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state");
   property p_start;
      s_req(8'h06, 8'h00, 3'h0) |=> ans_valid && ans_last && tag_state == 3'h1;
   endproperty
   a_start: assert property (p_start) else $error("start answer");
   property p_poll;
      s_req(8'h06, 8'h04, 3'h1) ##1 ans_valid |-> ans_byte[3:0] == 4'h0;
   endproperty
   a_poll: assert property (p_poll) else $error("poll slot");
   property p_requeue;
      s_req(8'hff, 8'h0c, 3'h3) |=> tag_state == 3'h1 && !ans_valid;
   endproperty
   a_requeue: assert property (p_requeue) else $error("requeue");
   property p_lock;
      tag_state == 3'h6 |=> tag_state == 3'h6 && !ans_valid && !mem_rd;
   endproperty
   a_lock: assert property (p_lock) else $error("lock");
   property p_crc;
      req_end && !req_crc_ok |=> $stable(tag_state) && !ans_valid;
   endproperty
   a_crc: assert property (p_crc) else $error("bad crc");
   property p_rd_gate;
      mem_rd |-> tag_state == 3'h3 && (mem_addr <= 8'h7f || mem_addr == 8'hff);
   endproperty
   a_rd_gate: assert property (p_rd_gate) else $error("read gate");
   property p_rd_data;
      rd_q |=> ans_valid && ans_byte == word_q[7:0];
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read byte");
endmodule
bind tacf_cmd_fsm tacf_cmd_fsm_sva #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .rst_n(rst_n),
   .req_valid(req_valid), .req_byte(req_byte), .req_end(req_end), .req_crc_ok(req_crc_ok),
   .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data), .ans_valid(ans_valid),
   .ans_byte(ans_byte), .ans_last(ans_last), .ans_ready(ans_ready), .tag_state(tag_state));

// *** sim/tacf_reader.sv ***
/* Far side: block memory and answer sink with stalls.
   Assumes one clock shared with the decoder. */
`timescale 1ns/100ps
module tacf_reader (
   input wire logic clk,
   input wire logic mem_rd,
   input wire logic [7:0] mem_addr,
   output logic [31:0] mem_data,
   input wire logic ans_valid,
   input wire logic [7:0] ans_byte,
   input wire logic ans_last,
   output logic ans_ready
);
   logic [7:0] got[$];
   int n_last = 0;
   initial ans_ready = 1'b0;
   initial mem_data = 32'h0;
   // Word one cycle after the strobe, noise otherwise; random stalls
   always @(posedge clk) begin
      mem_data <= mem_rd ? {~mem_addr, mem_addr, mem_addr ^ 8'h5a, mem_addr + 8'h01} : $urandom;
      ans_ready <= ($urandom % 3) != 0;
      if (ans_valid && ans_ready) begin
         got.push_back(ans_byte);
         n_last <= n_last + int'(ans_last);
      end
   end
endmodule

// *** sim/test_tacf_cmd_fsm.sv ***
/* Random and corner tests of the tag decoder.
   Assumes tacf_reader as memory and answer sink. */
`timescale 1ns/100ps
module test_tacf_cmd_fsm;
   logic clk, rst_n, req_valid, req_end, req_crc_ok, mem_rd, ans_valid, ans_last, ans_ready;
   logic [7:0] req_byte, ans_byte, mem_addr, h, a;
   logic [31:0] mem_data;
   logic [2:0] tag_state;
   int miscompares = 0, compares = 0, cyc = 0, hits;
   tacf_cmd_fsm dut_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_byte(req_byte),
      .req_end(req_end), .req_crc_ok(req_crc_ok), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_data(mem_data), .ans_valid(ans_valid), .ans_byte(ans_byte), .ans_last(ans_last),
      .ans_ready(ans_ready), .tag_state(tag_state));
   tacf_reader rdr_u (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data),
      .ans_valid(ans_valid), .ans_byte(ans_byte), .ans_last(ans_last), .ans_ready(ans_ready));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic end_sim;
      if (miscompares == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One frame, then wait for the last answer byte or a quiet spell
   task automatic frame(logic [7:0] c0, logic [7:0] c1, int n, logic ok);
      int k;
      rdr_u.got.delete();
      for (k = 0; k < n; k++) begin
         req_valid <= 1'b1;
         req_byte <= k ? c1 : c0;
         @(posedge clk);
      end
      req_valid <= 1'b0;
      req_end <= 1'b1;
      req_crc_ok <= ok;
      @(posedge clk);
      req_end <= 1'b0;
      k = rdr_u.n_last;
      for (int i = 0; i < 40 && rdr_u.n_last == k; i++) @(posedge clk);
      @(posedge clk);
   endtask
   always @(posedge clk) if (++cyc > 30000) begin
      miscompares++;
      end_sim();
   end
   // Main sequence
   initial begin
      void'($urandom(66876));
      {rst_n, req_valid, req_byte, req_end, req_crc_ok} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("ready", tag_state, 0);
      frame(8'h06, 8'h04, 2, 1);
      frame(8'h08, 8'h00, 2, 1);
      frame(8'h06, 8'h00, 2, 0);
      check("silent", {tag_state, rdr_u.got.size()}, 0);
      frame(8'h06, 8'h00, 2, 1);
      h = rdr_u.got[0];
      check("start", {tag_state, rdr_u.got.size()}, {3'h1, 32'h1});
      for (int r = 0; r < 6; r++) begin
         frame(8'h06, 8'h04, 2, 1);
         hits = rdr_u.got.size();
         if (hits) check("poll", rdr_u.got[0], {h[7:4], 4'h0});
         for (int s = 1; s < 16; s++) begin
            frame({s[3:0], 4'h6}, 8'h00, 1, 1);
            if (rdr_u.got.size()) check("probe", rdr_u.got[0], {h[7:4], s[3:0]});
            if (rdr_u.got.size()) h = rdr_u.got[0];
            hits += rdr_u.got.size();
         end
         check("answers", hits, 1);
      end
      frame(8'h0f, 8'h00, 1, 1);
      frame(8'h0e, ~h, 2, 1);
      check("ignored", {tag_state, rdr_u.got.size()}, {3'h1, 32'h0});
      frame(8'h0e, h, 2, 1);
      check("select", {tag_state, rdr_u.got[0]}, {3'h3, h});
      for (int r = 0; r < 16; r++) begin
         a = r < 5 ? 8'(40'h00_7f_80_fe_ff >> (8 * r)) : 8'($urandom);
         frame(8'h08, a, 2, r != 5);
         hits = (r != 5 && (a <= 8'h7f || a == 8'hff)) ? 4 : 0;
         check("read len", rdr_u.got.size(), hits);
         if (hits) check("read", {rdr_u.got[3], rdr_u.got[2], rdr_u.got[1], rdr_u.got[0]},
            {~a, a, a ^ 8'h5a, a + 8'h01});
      end
      frame(8'h0e, ~h, 2, 1);
      check("deselect", tag_state, 2);
      frame(8'h0e, h, 2, 1);
      frame(8'h0c, 8'h00, 1, 1);
      check("requeue", {tag_state, rdr_u.got.size()}, {3'h1, 32'h0});
      frame(8'h0e, h, 2, 1);
      frame(8'h0f, 8'h00, 1, 1);
      frame(8'h06, 8'h00, 2, 1);
      check("locked", {tag_state, rdr_u.got.size()}, {3'h6, 32'h0});
      end_sim();
   end
endmodule
